// File: verilog/tcr_map.vh
// Field positions, codes and reset values for the trace control registers
//Contract
//RL1 - Select bit picks software or hardware controls
//RL2 - Record-type bit chooses user type two/one
//RL3 - Branch bit: all taken or unpredictable only
//RL4 - Overflow inhibit forbids FIFO overflow or drops
//RL5 - Trace in debug mode only when enabled
//RL6 - Trace in exception mode only when enabled
//RL7 - Trace in kernel mode only when enabled
//RL8 - Trace in user mode only when enabled
//RL9 - Master enable plus one mode enable needed
//RL10 - Level field decodes which address/data traced
//RL11 - Unimplemented main bits read zero, bit four one
//RL12 - Status fields loaded from collector block
//RL13 - Supported level field: PC, addresses, data
//RL14 - Report whether both buffers are present
//RL15 - Report whether destination is off-chip buffer
//RL16 - Sync period from code and destination
//RL17 - Status register bits 31-7 read zero
//RL18 - User data write emits typed user record
//RL19 - Inhibited overflow stalls issue when FIFO full
//RL20 - Software never requests unsupported trace level
`ifndef TCR_MAP_VH
`define TCR_MAP_VH

`define TCR_SEL_MAIN 2'h1
`define TCR_SEL_STAT 2'h2
`define TCR_SEL_USER 2'h3

`define TCR_B_SELECT 31
`define TCR_B_UTYPE 30
`define TCR_B_BRANCH 27
`define TCR_B_INHIBIT 26
`define TCR_B_DEBUG 25
`define TCR_B_EXC 24
`define TCR_B_KERNEL 23
`define TCR_B_USER 21
`define TCR_B_ONE 4
`define TCR_B_LVL_HI 3
`define TCR_B_LVL_LO 1
`define TCR_B_ON 0

`define TCR_MAIN_RESET 32'h00000010
`define TCR_WMASK 32'hCFA0000F

`define TCR_S_LVL_HI 6
`define TCR_S_LVL_LO 5
`define TCR_S_BOTH 4
`define TCR_S_OFFCHIP 3
`define TCR_S_SYNC_HI 2
`define TCR_S_SYNC_LO 0

`define TCR_STAT_LVL_RESET 2'h2

`define TCR_SYNC_ONCHIP_BASE 4'h9
`define TCR_SYNC_OFFCHIP_ADD 4'h5

`endif

// File: verilog/tcr_mode_gate.v
// Per-mode and master enable gating of the trace stream
`include "tcr_map.vh"

module tcr_mode_gate (
    input wire on_en,
    input wire [3:0] mode_en,
    input wire [3:0] cpu_mode,
    output wire trace_active
);
    // cpu_mode is one-hot: {debug, exception, kernel, user}
    assign trace_active = on_en & |(mode_en & cpu_mode); // see RL5 RL6 RL7 RL8 RL9
endmodule // tcr_mode_gate

// File: verilog/tcr_level_decode.v
// Decode of the trace level field into per-item enables
`include "tcr_map.vh"

module tcr_level_decode (
    input wire [2:0] level,
    output wire trc_pc,
    output wire trc_ld_addr,
    output wire trc_st_addr,
    output wire trc_ld_data,
    output wire trc_st_data
);
    reg [3:0] sel;

    always @* begin
        case (level) // see RL10
            3'h0: sel = 4'h0;
            3'h1: sel = 4'h1;
            3'h2: sel = 4'h2;
            3'h3: sel = 4'h3;
            3'h4: sel = 4'h4;
            3'h5: sel = 4'h5;
            3'h6: sel = 4'hA;
            default: sel = 4'hF;
        endcase
    end

    assign trc_pc = 1'b1;
    assign trc_ld_addr = sel[0];
    assign trc_st_addr = sel[1];
    assign trc_ld_data = sel[2];
    assign trc_st_data = sel[3];
endmodule // tcr_level_decode

// File: verilog/tcr_trace_control.v
// Trace control and status registers with effective trace controls
`include "tcr_map.vh"

module tcr_trace_control (
    input wire clk_sys,
    input wire rst_b,
    input wire [1:0] reg_sel,
    input wire reg_wr,
    input wire [31:0] reg_wdata,
    output reg [31:0] reg_rdata,
    input wire hw_on,
    input wire [3:0] hw_mode_en,
    input wire [2:0] hw_level,
    input wire hw_branch_style,
    input wire hw_inhibit,
    input wire [1:0] collector_supported_levels,
    input wire collector_buffers_both,
    input wire collector_offchip,
    input wire [2:0] collector_sync_code,
    input wire collector_status_valid,
    input wire [3:0] cpu_mode,
    input wire fifo_full,
    output wire trace_active,
    output wire eff_branch_all,
    output wire eff_inhibit,
    output wire trc_pc,
    output wire trc_ld_addr,
    output wire trc_st_addr,
    output wire trc_ld_data,
    output wire trc_st_data,
    output wire issue_stall,
    output wire fifo_drop_ok,
    output reg [3:0] sync_period_log2,
    output reg usr_rec_valid,
    output reg usr_rec_type2,
    output reg [31:0] usr_rec_data
);
    // ----------------------------------------------------------------
    // Register request decode
    // ----------------------------------------------------------------
    localparam [31:0] MAIN_RESET = `TCR_MAIN_RESET;
    localparam [31:0] MAIN_WMASK = `TCR_WMASK;

    wire sel_main = (reg_sel == `TCR_SEL_MAIN);
    wire sel_stat = (reg_sel == `TCR_SEL_STAT);
    wire sel_user = (reg_sel == `TCR_SEL_USER);
    // A write strobe on select zero or on the status register goes nowhere
    wire wr_main = reg_wr & sel_main;
    wire wr_user = reg_wr & sel_user;

    // ----------------------------------------------------------------
    // Main control register
    // ----------------------------------------------------------------
    wire [31:0] ctl;
    genvar gi;

    // One flip-flop per bit; bits outside the write mask keep their reset
    // value for good, so the unimplemented ones always read back fixed
    generate
        for (gi = 0; gi < 32; gi = gi + 1) begin : g_ctl_bit
            reg bit_q;

            always @(posedge clk_sys or negedge rst_b) begin
                if (!rst_b) begin
                    bit_q <= MAIN_RESET[gi];
                end else if (wr_main && MAIN_WMASK[gi]) begin
                    bit_q <= reg_wdata[gi]; // see RL11
                end
            end

            assign ctl[gi] = bit_q;
        end
    endgenerate

    // ----------------------------------------------------------------
    // Main register fields
    // ----------------------------------------------------------------
    wire hw_sw_control_select = ctl[`TCR_B_SELECT];
    wire usr_record_kind = ctl[`TCR_B_UTYPE];
    wire branch_trace_style = ctl[`TCR_B_BRANCH];
    wire sw_inhibit = ctl[`TCR_B_INHIBIT];
    wire sw_mode_dbg = ctl[`TCR_B_DEBUG];
    wire sw_mode_exc = ctl[`TCR_B_EXC];
    wire sw_mode_ker = ctl[`TCR_B_KERNEL];
    wire sw_mode_usr = ctl[`TCR_B_USER];
    wire [2:0] sw_level = ctl[`TCR_B_LVL_HI:`TCR_B_LVL_LO];
    wire sw_on = ctl[`TCR_B_ON];

    // ----------------------------------------------------------------
    // Status register, captured from the collector block
    // ----------------------------------------------------------------
    reg [1:0] supported_trace_levels;
    reg buffers_both_present;
    reg offchip_destination;
    reg [2:0] sync_period_code;
    reg [1:0] next_supported_trace_levels;
    reg next_buffers_both_present;
    reg next_offchip_destination;
    reg [2:0] next_sync_period_code;

    // The collector owns these fields; software writes never reach them
    always @* begin
        next_supported_trace_levels = supported_trace_levels;
        next_buffers_both_present = buffers_both_present;
        next_offchip_destination = offchip_destination;
        next_sync_period_code = sync_period_code;
        if (collector_status_valid) begin
            next_supported_trace_levels = collector_supported_levels; // see RL12 RL13
            next_buffers_both_present = collector_buffers_both; // see RL12 RL14
            next_offchip_destination = collector_offchip; // see RL12 RL15
            next_sync_period_code = collector_sync_code; // see RL12 RL16
        end
    end

    // Until the collector drives them only the level field has a nonzero
    // power-up value; the rest start at zero rather than unknown
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            supported_trace_levels <= `TCR_STAT_LVL_RESET;
            buffers_both_present <= 1'b0;
            offchip_destination <= 1'b0;
            sync_period_code <= 3'h0;
        end else begin
            supported_trace_levels <= next_supported_trace_levels;
            buffers_both_present <= next_buffers_both_present;
            offchip_destination <= next_offchip_destination;
            sync_period_code <= next_sync_period_code;
        end
    end

    // ----------------------------------------------------------------
    // Software/hardware control selection
    // ----------------------------------------------------------------
    wire [3:0] sw_mode_en = {sw_mode_dbg, sw_mode_exc, sw_mode_ker, sw_mode_usr};
    wire [3:0] eff_mode_en;
    wire eff_on = hw_sw_control_select ? sw_on : hw_on; // see RL1
    // Level requests beyond the supported field are software's to avoid
    wire [2:0] eff_level = hw_sw_control_select ? sw_level : hw_level; // see RL1 RL20

    // Each mode enable follows the same select, one bit at a time
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_mode_sel
            assign eff_mode_en[gi] = hw_sw_control_select ?
                sw_mode_en[gi] : hw_mode_en[gi]; // see RL1 RL5 RL6 RL7 RL8
        end
    endgenerate

    assign eff_branch_all = hw_sw_control_select ?
        branch_trace_style : hw_branch_style; // see RL3
    assign eff_inhibit = hw_sw_control_select ? sw_inhibit : hw_inhibit; // see RL4

    // ----------------------------------------------------------------
    // Overflow handling
    // ----------------------------------------------------------------
    // Stalling trades speed for completeness: nothing drops when inhibited
    assign issue_stall = trace_active & eff_inhibit & fifo_full; // see RL4 RL19
    assign fifo_drop_ok = ~eff_inhibit; // see RL4

    tcr_mode_gate u_gate (
        .on_en(eff_on),
        .mode_en(eff_mode_en),
        .cpu_mode(cpu_mode),
        .trace_active(trace_active)
    );

    tcr_level_decode u_level (
        .level(eff_level),
        .trc_pc(trc_pc),
        .trc_ld_addr(trc_ld_addr),
        .trc_st_addr(trc_st_addr),
        .trc_ld_data(trc_ld_data),
        .trc_st_data(trc_st_data)
    );

    // ----------------------------------------------------------------
    // Sync period: log2 of the interval in trace cycles
    // ----------------------------------------------------------------
    reg [3:0] next_sync_period_log2;
    wire [3:0] sync_base_log2 = `TCR_SYNC_ONCHIP_BASE - {1'b0, sync_period_code};

    // Each code step halves the interval; off-chip adds five, a factor of
    // thirty-two
    always @* begin
        if (offchip_destination) begin
            next_sync_period_log2 = sync_base_log2 + `TCR_SYNC_OFFCHIP_ADD; // see RL16
        end else begin
            next_sync_period_log2 = sync_base_log2; // see RL16
        end
    end

    // Registered so the period seen downstream never glitches on a capture
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sync_period_log2 <= `TCR_SYNC_ONCHIP_BASE;
        end else begin
            sync_period_log2 <= next_sync_period_log2;
        end
    end

    // ----------------------------------------------------------------
    // User trace record on a data write
    // ----------------------------------------------------------------
    reg next_usr_rec_type2;
    reg [31:0] next_usr_rec_data;

    // Type and payload hold between writes; only the valid strobe pulses
    always @* begin
        next_usr_rec_type2 = usr_rec_type2;
        next_usr_rec_data = usr_rec_data;
        if (wr_user) begin
            next_usr_rec_type2 = usr_record_kind; // see RL2 RL18
            next_usr_rec_data = reg_wdata; // see RL18
        end
    end

    // A write every cycle gives a record every cycle; software must space them
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            usr_rec_valid <= 1'b0;
            usr_rec_type2 <= 1'b0;
            usr_rec_data <= 32'h00000000;
        end else begin
            usr_rec_valid <= wr_user; // see RL18
            usr_rec_type2 <= next_usr_rec_type2;
            usr_rec_data <= next_usr_rec_data;
        end
    end

    // ----------------------------------------------------------------
    // Read words
    // ----------------------------------------------------------------
    wire [31:0] main_word = ctl; // see RL11
    wire [31:0] stat_word;

    assign stat_word[31:`TCR_S_LVL_HI + 1] = 25'h0; // see RL17
    assign stat_word[`TCR_S_LVL_HI:`TCR_S_LVL_LO] = supported_trace_levels; // see RL13
    assign stat_word[`TCR_S_BOTH] = buffers_both_present; // see RL14
    assign stat_word[`TCR_S_OFFCHIP] = offchip_destination; // see RL15
    assign stat_word[`TCR_S_SYNC_HI:`TCR_S_SYNC_LO] = sync_period_code; // see RL16

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    always @* begin
        if (sel_main) begin
            reg_rdata = main_word;
        end else if (sel_stat) begin
            reg_rdata = stat_word;
        end else if (sel_user) begin
            reg_rdata = usr_rec_data;
        end else begin
            reg_rdata = 32'h00000000;
        end
    end
endmodule // tcr_trace_control

// File: testbench/tcr_trace_control_sva.sv
// Port assertions for the trace control register block
module tcr_trace_control_sva (
    input wire clk_sys,
    input wire rst_b,
    input wire [1:0] reg_sel,
    input wire reg_wr,
    input wire [31:0] reg_wdata,
    input wire [31:0] reg_rdata,
    input wire fifo_full,
    input wire trace_active,
    input wire eff_branch_all,
    input wire eff_inhibit,
    input wire trc_pc,
    input wire issue_stall,
    input wire fifo_drop_ok,
    input wire usr_rec_valid,
    input wire [31:0] usr_rec_data
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    property p_stall; issue_stall == (trace_active && eff_inhibit && fifo_full); endproperty
    a_stall: assert property (p_stall) else $error("stall mismatch");
    property p_drop; fifo_drop_ok != eff_inhibit; endproperty
    a_drop: assert property (p_drop) else $error("drop mismatch");
    property p_pc; trc_pc; endproperty
    a_pc: assert property (p_pc) else $error("pc not traced");
    property p_sw; reg_sel == 2'h1 && reg_rdata[31] |->
        eff_branch_all == reg_rdata[27] && eff_inhibit == reg_rdata[26]; endproperty
    a_sw: assert property (p_sw) else $error("soft controls ignored");
    property p_on; reg_sel == 2'h1 && reg_rdata[31] && !reg_rdata[0] |-> !trace_active; endproperty
    a_on: assert property (p_on) else $error("trace without master");
    property p_rsv; reg_sel == 2'h1 |-> reg_rdata[4] && reg_rdata[29:28] == 2'h0 &&
        !reg_rdata[22] && reg_rdata[20:5] == 16'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("main filler bits");
    property p_stat; reg_sel == 2'h2 |-> reg_rdata[31:7] == 25'h0; endproperty
    a_stat: assert property (p_stat) else $error("status filler bits");
    property p_usr; reg_wr && reg_sel == 2'h3 |=>
        usr_rec_valid && usr_rec_data == $past(reg_wdata); endproperty
    a_usr: assert property (p_usr) else $error("no user record");
    property p_one; usr_rec_valid |-> $past(reg_wr) && $past(reg_sel) == 2'h3; endproperty
    a_one: assert property (p_one) else $error("stray user record");
endmodule // tcr_trace_control_sva

bind tcr_trace_control tcr_trace_control_sva tcr_trace_control_sva_inst (.*);

// File: testbench/tcr_collector_model.sv
// Behavioural trace collector block: status fields and FIFO full flag
module tcr_collector_model (
    input wire clk_sys,
    input wire load,
    input wire [6:0] cfg,
    output reg [6:0] stat,
    output reg status_valid,
    output reg fifo_full
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {stat, status_valid, fifo_full} = 9'h000;
    always @(posedge clk_sys) begin
        fifo_full <= 1'($urandom);
        status_valid <= load;
        // Outside the valid cycle the lines toggle so a stale capture shows
        stat <= load ? cfg : ~stat;
    end
endmodule // tcr_collector_model

// File: testbench/trace_control_registers_tb_top.sv
// Self-checking bench for the trace control register block
module trace_control_registers_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'h0, rst_b = 1'h0, reg_wr = 1'h0, probe = 1'h0, load = 1'h0;
    logic hw_on = 1'h0, hw_br = 1'h0, hw_inh = 1'h0;
    logic [1:0] reg_sel = 2'h0;
    logic [3:0] hw_men = 4'h0, cpu_mode = 4'h1, sp = 4'h9, slog;
    logic [2:0] hw_lvl = 3'h0;
    logic [6:0] cfg = 7'h00, stat;
    logic [31:0] reg_wdata = 32'h0, main = 32'h10, st = 32'h40, d, rdata, udata;
    logic vld, full, act, pc, la, sa, ld, sd, br, inh, uv, rkind;
    logic [42:0] q[$];
    int errors = 0, total_checks = 0;
    always #4 clk_sys = ~clk_sys;
    tcr_trace_control tcr_trace_control_inst (.clk_sys(clk_sys), .rst_b(rst_b),
        .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(rdata),
        .hw_on(hw_on), .hw_mode_en(hw_men), .hw_level(hw_lvl), .hw_branch_style(hw_br),
        .hw_inhibit(hw_inh), .collector_supported_levels(stat[6:5]),
        .collector_buffers_both(stat[4]), .collector_offchip(stat[3]),
        .collector_sync_code(stat[2:0]), .collector_status_valid(vld),
        .cpu_mode(cpu_mode), .fifo_full(full), .trace_active(act), .eff_branch_all(br),
        .eff_inhibit(inh), .trc_pc(pc), .trc_ld_addr(la), .trc_st_addr(sa), .trc_ld_data(ld),
        .trc_st_data(sd), .issue_stall(), .fifo_drop_ok(), .sync_period_log2(slog),
        .usr_rec_valid(uv), .usr_rec_type2(rkind), .usr_rec_data(udata));
    tcr_collector_model tcr_collector_model_inst (.clk_sys(clk_sys), .load(load), .cfg(cfg),
        .stat(stat), .status_valid(vld), .fifo_full(full));
    function automatic logic [6:0] ctl(input logic [31:0] m);
        logic [2:0] l;
        l = m[31] ? m[3:1] : hw_lvl;
        return {m[31] ? m[0] & |(cpu_mode & {m[25:23], m[21]}) : hw_on & |(cpu_mode & hw_men),
            l[0], l[1], l[2] & (l != 3'h6), l[2] & l[1], m[31] ? m[27:26] : {hw_br, hw_inh}};
    endfunction
    task automatic wr(input logic [1:0] s, input logic [31:0] v);
        @(posedge clk_sys);
        reg_sel <= s;
        reg_wr <= 1'h1;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [1:0] s, input logic [31:0] v);
        @(posedge clk_sys);
        q.push_back({v, sp, ctl(main)});
        reg_sel <= s;
        probe <= 1'h1;
        @(posedge clk_sys);
        probe <= 1'h0;
    endtask
    task give_verdict;
        if (errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Reads and user records never share a cycle, so one queue serves both
    always @(negedge clk_sys) begin
        if (probe || uv) begin
            total_checks++;
            if (q.size() == 0 || q.pop_front() !== (probe ?
                {rdata, slog, act, la, sa, ld, sd, br, inh} : {udata, rkind, 10'h000})) begin
                errors++;
                $display("Error %0t: result mismatch", $time);
            end
        end
    end
    initial begin
        #20us;
        errors++;
        give_verdict();
    end
    initial begin
        void'($urandom(76738));
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'h1;
        rd(2'h1, main);
        rd(2'h2, st);
        rd(2'h0, 32'h0);
        repeat (40) begin
            @(posedge clk_sys);
            {hw_on, hw_men, hw_lvl, hw_br, hw_inh} <= 10'($urandom);
            cpu_mode <= 4'h1 << $urandom_range(3);
            d = $urandom;
            wr(2'h1, d);
            main = d & 32'hCFA0000F | 32'h10;
            rd(2'h1, main);
            wr(2'h2, ~d);
            q.push_back({d, main[30], 10'h000});
            wr(2'h3, d);
            rd(2'h3, d);
            rd(2'h2, st);
        end
        for (int i = 0; i < 16; i++) begin
            st = {25'h0, 2'($urandom_range(2)), 1'($urandom), 4'(i)};
            @(posedge clk_sys);
            cfg <= st[6:0];
            load <= 1'h1;
            @(posedge clk_sys);
            load <= 1'h0;
            repeat (3) @(posedge clk_sys);
            sp = 4'h9 - st[2:0] + (st[3] ? 4'h5 : 4'h0);
            rd(2'h2, st);
        end
        give_verdict();
    end
endmodule // trace_control_registers_tb_top
